// file: rtl/core_status_and_exception_entry.sv
// Status word, banked registers and exception entry and return sequencer
`timescale 1ns/1ps
`default_nettype none
module core_status_and_exception_entry
  import core_status_pkg::*;
#(
  parameter int unsigned XLEN = WORD_W
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        warm_reset_i,
  input  wire logic        data_abort_i,
  input  wire logic        fiq_req_i,
  input  wire logic        irq_req_i,
  input  wire logic        fetch_valid_i,
  input  wire logic        fetch_abort_i,
  input  wire logic        fetch_brk_i,
  input  wire logic        advance_i,
  input  wire logic        flush_i,
  input  wire logic        exec_undef_i,
  input  wire logic        exec_swint_i,
  input  wire logic [31:0] pc_i,
  input  wire logic        flags_we_i,
  input  wire logic [3:0]  flags_i,
  input  wire logic        sat_set_i,
  input  wire logic        status_wr_i,
  input  wire logic        status_wr_saved_i,
  input  wire logic [31:0] status_wr_data_i,
  input  wire logic        exc_return_i,
  input  wire logic [3:0]  cond_i,
  input  wire logic        reg_wr_i,
  input  wire logic [3:0]  reg_waddr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic [3:0]  reg_raddr_i,
  output logic [31:0]      status_o,
  output logic [31:0]      saved_status_o,
  output logic             cond_pass_o,
  output logic [31:0]      reg_rdata_o,
  output logic             pc_load_o,
  output logic [31:0]      pc_target_o,
  output logic             entry_busy_o
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (XLEN != WORD_W) begin : g_bad_width
    $error("Only a 32-bit word is supported");
  end

  // ****************************************************************
  // Decoding functions
  // ****************************************************************
  function automatic logic [2:0] mode_bank(input logic [4:0] m);
    case (m)
      MODE_FIQ: mode_bank = BANK_FIQ;
      MODE_IRQ: mode_bank = BANK_IRQ;
      MODE_SVC: mode_bank = BANK_SVC;
      MODE_ABT: mode_bank = BANK_ABT;
      MODE_UND: mode_bank = BANK_UND;
      default:  mode_bank = BANK_USR;
    endcase
  endfunction

  function automatic logic [4:0] exc_mode(input exc_t e);
    case (e)
      EXC_FIQ:                     exc_mode = MODE_FIQ;
      EXC_IRQ:                     exc_mode = MODE_IRQ;
      EXC_DABT, EXC_PABT, EXC_BREAK: exc_mode = MODE_ABT;
      EXC_UND:                     exc_mode = MODE_UND;
      default:                     exc_mode = MODE_SVC;
    endcase
  endfunction

  function automatic logic [31:0] exc_vector(input exc_t e);
    case (e)
      EXC_DABT:           exc_vector = VEC_DABT;
      EXC_FIQ:            exc_vector = VEC_FIQ;
      EXC_IRQ:            exc_vector = VEC_IRQ;
      EXC_PABT, EXC_BREAK: exc_vector = VEC_PABT;
      EXC_UND:            exc_vector = VEC_UND;
      EXC_SWINT:          exc_vector = VEC_SWINT;
      default:            exc_vector = VEC_RESET;
    endcase
  endfunction

  function automatic logic [31:0] link_off(input exc_t e, input logic cmp);
    case (e)
      EXC_DABT:         link_off = OFF_8;
      EXC_UND, EXC_SWINT: link_off = cmp ? OFF_2 : OFF_4;
      default:          link_off = OFF_4;
    endcase
  endfunction

  function automatic logic cond_eval(input logic [3:0] c, input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    n  = f[3];
    z  = f[2];
    cy = f[1];
    v  = f[0];
    case (c)
      4'h0: cond_eval = z;
      4'h1: cond_eval = !z;
      4'h2: cond_eval = cy;
      4'h3: cond_eval = !cy;
      4'h4: cond_eval = n;
      4'h5: cond_eval = !n;
      4'h6: cond_eval = v;
      4'h7: cond_eval = !v;
      4'h8: cond_eval = cy && !z;
      4'h9: cond_eval = !cy || z;
      4'ha: cond_eval = n == v;
      4'hb: cond_eval = n != v;
      4'hc: cond_eval = !z && (n == v);
      4'hd: cond_eval = z || (n != v);
      4'he: cond_eval = 1'b1;
      default: cond_eval = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    state_t                 state;
    exc_t                   exc;
    logic [31:0]            pc;
    logic                   cmp;
    logic [31:0]            current_status_word;
    logic [SAVED_N-1:0][31:0] saved_status_word;
    logic [BANK_N-1:0][31:0]  r13;
    logic [BANK_N-1:0][31:0]  r14;
    logic [HI_N-1:0][31:0]    hi_usr;
    logic [HI_N-1:0][31:0]    hi_fiq;
    logic                   dec_pabt;
    logic                   dec_brk;
    logic                   ex_pabt;
    logic                   ex_brk;
    logic                   abt_data;
    logic                   pc_load;
    logic [31:0]            pc_target;
    logic                   cond_pass;
    logic [31:0]            rdata;
    logic [31:0]            saved_view;
    logic                   busy;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;
  exc_t        pick;
  logic [2:0]  bank;
  logic [2:0]  new_bank;
  logic [2:0]  hi_w;
  logic [2:0]  hi_r;
  logic [31:0] ret_off;

  assign bank     = mode_bank(s_q.current_status_word[MODE_LSB +: MODE_W]);
  assign new_bank = mode_bank(exc_mode(s_q.exc));
  assign hi_w     = 3'(reg_waddr_i - HI_FIRST);
  assign hi_r     = 3'(reg_raddr_i - HI_FIRST);

  // ****************************************************************
  // Priority selection
  // ****************************************************************
  always_comb begin
    if (warm_reset_i) begin
      pick = EXC_RESET;
    end else if (data_abort_i) begin
      pick = EXC_DABT;
    end else if (fiq_req_i && !s_q.current_status_word[FIQ_DIS_BIT]) begin
      pick = EXC_FIQ;
    end else if (irq_req_i && !s_q.current_status_word[IRQ_DIS_BIT]) begin
      pick = EXC_IRQ;
    end else if (s_q.ex_pabt) begin
      pick = EXC_PABT;
    end else if (s_q.ex_brk) begin
      pick = EXC_BREAK;
    end else if (exec_undef_i) begin
      pick = EXC_UND;
    end else if (exec_swint_i) begin
      pick = EXC_SWINT;
    end else begin
      pick = EXC_NONE;
    end
  end

  always_comb begin
    case (bank)
      BANK_FIQ, BANK_IRQ: ret_off = OFF_4;
      BANK_ABT:           ret_off = s_q.abt_data ? OFF_8 : OFF_4;
      default:            ret_off = OFF_0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d           = s_q;
    s_d.pc_load   = 1'b0;
    s_d.cond_pass = cond_eval(cond_i, s_q.current_status_word[31:28]);
    if (flush_i || s_q.state == ST_VECTOR) begin
      s_d.dec_pabt = 1'b0;
      s_d.dec_brk  = 1'b0;
      s_d.ex_pabt  = 1'b0;
      s_d.ex_brk   = 1'b0;
    end else if (advance_i) begin
      s_d.ex_pabt  = s_q.dec_pabt;
      s_d.ex_brk   = s_q.dec_brk;
      s_d.dec_pabt = fetch_valid_i && fetch_abort_i;
      s_d.dec_brk  = fetch_valid_i && fetch_brk_i;
    end
    case (s_q.state)
      ST_IDLE: begin
        if (pick != EXC_NONE) begin
          s_d.state = ST_LINK;
          s_d.exc   = pick;
          s_d.pc    = pc_i;
          s_d.cmp   = s_q.current_status_word[CMP_BIT] && !s_q.current_status_word[BYTE_BIT];
        end else if (exc_return_i && bank != BANK_USR) begin
          s_d.current_status_word = s_q.saved_status_word[3'(bank - 3'h1)];
          s_d.pc_load   = 1'b1;
          s_d.pc_target = s_q.r14[bank] - ret_off;
        end else if (status_wr_i) begin
          if (status_wr_saved_i && bank != BANK_USR) begin
            s_d.saved_status_word[3'(bank - 3'h1)] = status_wr_data_i;
          end else if (bank == BANK_USR) begin
            s_d.current_status_word[31:27] = status_wr_data_i[31:27];
          end else begin
            s_d.current_status_word = status_wr_data_i;
          end
        end
        if (pick == EXC_NONE && reg_wr_i && reg_waddr_i >= HI_FIRST) begin
          if (reg_waddr_i == SP_IDX) begin
            s_d.r13[bank] = reg_wdata_i;
          end else if (reg_waddr_i == LINK_IDX) begin
            s_d.r14[bank] = reg_wdata_i;
          end else if (reg_waddr_i != 4'hf && bank == BANK_FIQ) begin
            s_d.hi_fiq[hi_w] = reg_wdata_i;
          end else if (reg_waddr_i != 4'hf) begin
            s_d.hi_usr[hi_w] = reg_wdata_i;
          end
        end
      end
      ST_LINK: begin
        if (s_q.exc != EXC_RESET) begin
          s_d.r14[new_bank] = s_q.pc + link_off(s_q.exc, s_q.cmp);
        end
        s_d.state = ST_SAVE;
      end
      ST_SAVE: begin
        s_d.saved_status_word[3'(new_bank - 3'h1)] = s_q.current_status_word;
        s_d.state = ST_MODE;
      end
      ST_MODE: begin
        s_d.current_status_word[MODE_LSB +: MODE_W] = exc_mode(s_q.exc);
        s_d.current_status_word[CMP_BIT]     = 1'b0;
        s_d.current_status_word[BYTE_BIT]    = 1'b0;
        s_d.current_status_word[IRQ_DIS_BIT] = 1'b1;
        if (s_q.exc == EXC_FIQ || s_q.exc == EXC_RESET) begin
          s_d.current_status_word[FIQ_DIS_BIT] = 1'b1;
        end
        if (new_bank == BANK_ABT) begin
          s_d.abt_data = s_q.exc == EXC_DABT;
        end
        s_d.state = ST_VECTOR;
      end
      ST_VECTOR: begin
        s_d.pc_load   = 1'b1;
        s_d.pc_target = exc_vector(s_q.exc);
        s_d.state     = ST_IDLE;
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
    if (flags_we_i) begin
      s_d.current_status_word[NEG_BIT:OVF_BIT] = flags_i;
    end
    if (sat_set_i) begin
      s_d.current_status_word[SAT_BIT] = 1'b1;
    end
    if (reg_raddr_i == SP_IDX) begin
      s_d.rdata = s_q.r13[bank];
    end else if (reg_raddr_i == LINK_IDX) begin
      s_d.rdata = s_q.r14[bank];
    end else if (reg_raddr_i >= HI_FIRST && reg_raddr_i != 4'hf) begin
      s_d.rdata = (bank == BANK_FIQ) ? s_q.hi_fiq[hi_r] : s_q.hi_usr[hi_r];
    end else begin
      s_d.rdata = 32'h0000_0000;
    end
    // Registered views of the saved word and the busy flag
    if (mode_bank(s_d.current_status_word[MODE_LSB +: MODE_W]) == BANK_USR) begin
      s_d.saved_view = 32'h0000_0000;
    end else begin
      s_d.saved_view = s_d.saved_status_word[3'(mode_bank(s_d.current_status_word[MODE_LSB +: MODE_W]) - 3'h1)];
    end
    s_d.busy = s_d.state != ST_IDLE;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q       <= '0;
      s_q.state <= ST_VECTOR;
      s_q.exc   <= EXC_RESET;
      s_q.current_status_word <= RESET_STATUS;
      s_q.busy  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign status_o       = s_q.current_status_word;
  assign saved_status_o = s_q.saved_view;
  assign cond_pass_o    = s_q.cond_pass;
  assign reg_rdata_o    = s_q.rdata;
  assign pc_load_o      = s_q.pc_load;
  assign pc_target_o    = s_q.pc_target;
  assign entry_busy_o   = s_q.busy;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_entry_walk;
    s_q.state == ST_LINK ##1 s_q.state == ST_SAVE ##1 s_q.state == ST_MODE ##1 s_q.state == ST_VECTOR;
  endsequence

  property p_entry_order;
    (s_q.state == ST_IDLE && pick != EXC_NONE) |=> s_entry_walk ##1 (pc_load_o && s_q.state == ST_IDLE);
  endproperty
  a_entry_order: assert property (p_entry_order) else $error("Entry steps out of order");

  property p_vector;
    s_q.state == ST_VECTOR |=> pc_target_o == exc_vector($past(s_q.exc));
  endproperty
  a_vector: assert property (p_vector) else $error("Wrong vector");

  property p_mode_force;
    s_q.state == ST_MODE |=> status_o[4:0] == exc_mode(s_q.exc) && status_o[IRQ_DIS_BIT];
  endproperty
  a_mode_force: assert property (p_mode_force) else $error("Mode not forced");

  property p_sat_sticky;
    (status_o[SAT_BIT] && !((status_wr_i || exc_return_i) && s_q.state == ST_IDLE)) |=> status_o[SAT_BIT];
  endproperty
  a_sat_sticky: assert property (p_sat_sticky) else $error("Saturation flag lost");

  property p_abort_first;
    (s_q.state == ST_IDLE && !warm_reset_i && data_abort_i && fiq_req_i) |=> s_q.exc == EXC_DABT;
  endproperty
  a_abort_first: assert property (p_abort_first) else $error("Abort not first");

  property p_irq_masked;
    pick == EXC_IRQ |-> !status_o[IRQ_DIS_BIT] && !fiq_req_i || status_o[FIQ_DIS_BIT];
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("Masked request taken");

  property p_flush_drop;
    flush_i |=> !s_q.ex_pabt && !s_q.ex_brk && !s_q.dec_pabt && !s_q.dec_brk;
  endproperty
  a_flush_drop: assert property (p_flush_drop) else $error("Flushed abort kept");

  property p_save;
    s_q.state == ST_SAVE |=> s_q.saved_status_word[3'(new_bank - 3'h1)] == $past(status_o);
  endproperty
  a_save: assert property (p_save) else $error("Status not saved");

  property p_link;
    (s_q.state == ST_LINK && s_q.exc != EXC_RESET)
      |=> s_q.r14[new_bank] == $past(s_q.pc) + link_off(s_q.exc, s_q.cmp);
  endproperty
  a_link: assert property (p_link) else $error("Wrong link value");

  property p_return;
    (s_q.state == ST_IDLE && pick == EXC_NONE && exc_return_i && bank != BANK_USR)
      |=> pc_load_o && status_o == $past(saved_status_o);
  endproperty
  a_return: assert property (p_return) else $error("Return did not restore");

endmodule
`default_nettype wire

// file: rtl/core_status_pkg.sv
// Constants and types for the status word and exception entry block
package core_status_pkg;

  // ****************************************************************
  // Status word layout
  // ****************************************************************
  localparam int unsigned WORD_W   = 32;
  localparam int unsigned SAVED_N  = 5;
  localparam int unsigned BANK_N   = 6;
  localparam int unsigned HI_N     = 5;
  localparam int unsigned NEG_BIT  = 31;
  localparam int unsigned ZERO_BIT = 30;
  localparam int unsigned CARRY_BIT = 29;
  localparam int unsigned OVF_BIT  = 28;
  localparam int unsigned SAT_BIT  = 27;
  localparam int unsigned BYTE_BIT = 24;
  localparam int unsigned IRQ_DIS_BIT = 7;
  localparam int unsigned FIQ_DIS_BIT = 6;
  localparam int unsigned CMP_BIT  = 5;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W   = 5;
  localparam logic [31:0] RESET_STATUS = 32'h0000_00d3;

  // ****************************************************************
  // Mode encodings
  // ****************************************************************
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1b;
  localparam logic [4:0] MODE_SYS = 5'h1f;

  // Bank indices: 0 shared, then one per exception mode
  localparam logic [2:0] BANK_USR = 3'h0;
  localparam logic [2:0] BANK_FIQ = 3'h1;
  localparam logic [2:0] BANK_IRQ = 3'h2;
  localparam logic [2:0] BANK_SVC = 3'h3;
  localparam logic [2:0] BANK_ABT = 3'h4;
  localparam logic [2:0] BANK_UND = 3'h5;

  // ****************************************************************
  // Vectors, link or return offsets and register indices
  // ****************************************************************
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UND   = 32'h0000_0004;
  localparam logic [31:0] VEC_SWINT = 32'h0000_0008;
  localparam logic [31:0] VEC_PABT  = 32'h0000_000c;
  localparam logic [31:0] VEC_DABT  = 32'h0000_0010;
  localparam logic [31:0] VEC_IRQ   = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ   = 32'h0000_001c;
  localparam logic [31:0] OFF_2     = 32'h0000_0002;
  localparam logic [31:0] OFF_4     = 32'h0000_0004;
  localparam logic [31:0] OFF_8     = 32'h0000_0008;
  localparam logic [31:0] OFF_0     = 32'h0000_0000;
  localparam logic [3:0]  HI_FIRST  = 4'h8;
  localparam logic [3:0]  SP_IDX    = 4'hd;
  localparam logic [3:0]  LINK_IDX  = 4'he;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_LINK   = 3'h1,
    ST_SAVE   = 3'h3,
    ST_MODE   = 3'h2,
    ST_VECTOR = 3'h6
  } state_t;

  typedef enum logic [3:0] {
    EXC_NONE  = 4'h0,
    EXC_RESET = 4'h1,
    EXC_DABT  = 4'h2,
    EXC_FIQ   = 4'h3,
    EXC_IRQ   = 4'h4,
    EXC_PABT  = 4'h5,
    EXC_BREAK = 4'h6,
    EXC_UND   = 4'h7,
    EXC_SWINT = 4'h8
  } exc_t;

endpackage

// file: verif/exc_source_model.sv
// Interrupt controller and abort source facing the exception block
`timescale 1ns/1ps
`default_nettype none
module exc_source_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       busy_i,
  input  wire logic [3:0] set_i,
  input  wire logic [3:0] clr_i,
  input  wire logic [3:0] delay_i,
  output logic      [3:0] req_o
);
  // ********
  // Request lines: 0 warm reset, 1 data abort, 2 fast, 3 normal
  // ********
  logic [3:0] pend_q;
  logic [3:0] wait_q;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pend_q <= 4'h0;
      wait_q <= 4'h0;
    end else begin
      // Reset and abort are one-shot; interrupts hold until cleared
      pend_q <= (pend_q | set_i) & ~clr_i & ~({4{busy_i}} & 4'h3);
      wait_q <= (|set_i) ? delay_i : wait_q - {3'h0, |wait_q};
    end
  end
  // Requests show only once the chosen delay has run out
  assign req_o = (wait_q == 4'h0) ? pend_q : 4'h0;
endmodule
`default_nettype wire

// file: verif/core_status_and_exception_entry_test.sv
// Self-checking bench for the status word and exception entry block
`timescale 1ns/1ps
`default_nettype none
module core_status_and_exception_entry_test;
  import core_status_pkg::*;
  // ********
  // Signals and instances
  // ********
  logic        clk_i, rst_b_i, fetch_valid_i, fetch_abort_i, fetch_brk_i;
  logic        advance_i, flush_i, exec_undef_i, exec_swint_i, flags_we_i;
  logic        sat_set_i, status_wr_i, status_wr_saved_i, exc_return_i;
  logic        reg_wr_i, cond_pass_o, pc_load_o, entry_busy_o;
  logic [3:0]  flags_i, cond_i, reg_waddr_i, reg_raddr_i, set_q, clr_q, dly_q;
  logic [31:0] pc_i, status_wr_data_i, reg_wdata_i, status_o, saved_status_o;
  logic [31:0] reg_rdata_o, pc_target_o;
  wire logic   warm_reset_i, data_abort_i, fiq_req_i, irq_req_i;
  logic [15:0] rnd;
  logic [31:0] exp_q[$];
  int          err_total, total_checks, cyc;

  initial clk_i = 1'b0;
  always #50 clk_i = ~clk_i;

  core_status_and_exception_entry dut (
    .clk_i, .rst_b_i, .warm_reset_i, .data_abort_i, .fiq_req_i, .irq_req_i,
    .fetch_valid_i, .fetch_abort_i, .fetch_brk_i, .advance_i, .flush_i,
    .exec_undef_i, .exec_swint_i, .pc_i, .flags_we_i, .flags_i, .sat_set_i,
    .status_wr_i, .status_wr_saved_i, .status_wr_data_i, .exc_return_i,
    .cond_i, .reg_wr_i, .reg_waddr_i, .reg_wdata_i, .reg_raddr_i, .status_o,
    .saved_status_o, .cond_pass_o, .reg_rdata_o, .pc_load_o, .pc_target_o,
    .entry_busy_o
  );
  exc_source_model partner (
    .clk_i, .rst_b_i, .busy_i(entry_busy_o), .set_i(set_q), .clr_i(clr_q),
    .delay_i(dly_q), .req_o({irq_req_i, fiq_req_i, data_abort_i, warm_reset_i})
  );

  // ********
  // Helpers
  // ********
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic ceval(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = f[3] ~^ f[0];
      3'h6: r = ~f[2] & (f[3] ~^ f[0]);
      default: r = 1'b1;
    endcase
    return (c[0] && c[3:1] != 3'h7) ? ~r : r;
  endfunction

  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Watcher: every vector load is matched against the oldest note
  always @(posedge clk_i) begin
    cyc++;
    if (pc_load_o === 1'b1) begin
      if (exp_q.size() == 0) cmp({31'h0, pc_load_o}, 32'h0);
      else cmp(pc_target_o, exp_q.pop_front());
    end
    if (cyc > 4000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic wait_load();
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    while (pc_load_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 20) cmp(32'h0, 32'h1);
  endtask

  task automatic src(input logic [3:0] s, input logic [3:0] c, input logic [3:0] d);
    @(posedge clk_i);
    set_q <= s;
    clr_q <= c;
    dly_q <= d;
    @(posedge clk_i);
    set_q <= 4'h0;
    clr_q <= 4'h0;
  endtask

  task automatic wr_st(input logic sv, input logic [31:0] d);
    @(posedge clk_i);
    status_wr_i <= 1'b1;
    status_wr_saved_i <= sv;
    status_wr_data_i <= d;
    @(posedge clk_i);
    status_wr_i <= 1'b0;
    status_wr_saved_i <= 1'b0;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_waddr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_raddr_i <= a;
    @(posedge clk_i);
    #1;
    cmp(reg_rdata_o, e);
  endtask

  task automatic exec(input logic u, input logic s);
    @(posedge clk_i);
    exec_undef_i <= u;
    exec_swint_i <= s;
    @(posedge clk_i);
    exec_undef_i <= 1'b0;
    exec_swint_i <= 1'b0;
  endtask

  task automatic fetch(input logic ab, input logic bk, input logic fl);
    @(posedge clk_i);
    {fetch_valid_i, fetch_abort_i, fetch_brk_i, advance_i} <= {1'b1, ab, bk, 1'b1};
    @(posedge clk_i);
    {fetch_valid_i, fetch_abort_i, fetch_brk_i} <= 3'h0;
    advance_i <= ~fl;
    flush_i <= fl;
    @(posedge clk_i);
    advance_i <= 1'b0;
    flush_i <= 1'b0;
  endtask

  task automatic ret(input logic [31:0] tgt);
    exp_q.push_back(tgt);
    @(posedge clk_i);
    exc_return_i <= 1'b1;
    @(posedge clk_i);
    exc_return_i <= 1'b0;
    #1;
    cmp({31'h0, pc_load_o}, 32'h1);
  endtask

  task automatic run(input logic [31:0] st, input int k, input logic [31:0] vec,
                     input logic [31:0] mst, input logic [31:0] lo, input logic [31:0] ro);
    logic [31:0] pc;
    rnd = lfsr(rnd);
    pc = {14'h0, rnd, 2'h0};
    wr_st(1'b0, st);
    pc_i <= pc;
    exp_q.push_back(vec);
    case (k)
      0: exec(1'b1, 1'b0);
      1: exec(1'b0, 1'b1);
      2: fetch(1'b1, 1'b0, 1'b0);
      3: fetch(1'b0, 1'b1, 1'b0);
      default: src(4'h8, 4'h0, 4'h0);
    endcase
    wait_load();
    cmp(status_o, mst);
    cmp(saved_status_o, st);
    rd(LINK_IDX, pc + lo);
    src(4'h0, 4'h8, 4'h0);
    ret(pc + lo - ro);
    cmp(status_o, st);
  endtask

  initial begin
    rst_b_i = 1'b0;
    {fetch_valid_i, fetch_abort_i, fetch_brk_i, advance_i, flush_i} = 5'h0;
    {exec_undef_i, exec_swint_i, flags_we_i, sat_set_i, status_wr_i} = 5'h0;
    {status_wr_saved_i, exc_return_i, reg_wr_i} = 3'h0;
    {flags_i, cond_i, reg_waddr_i, reg_raddr_i, set_q, clr_q, dly_q} = 28'h0;
    {pc_i, status_wr_data_i, reg_wdata_i} = 96'h0;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    rnd = 16'hd42d;
    exp_q.push_back(VEC_RESET);
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    #1;
    cmp(status_o, 32'h0000_00d3);
    for (int i = 0; i < 15; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk_i);
      flags_we_i <= 1'b1;
      flags_i <= rnd[3:0];
      sat_set_i <= rnd[4] | (i == 0);
      @(posedge clk_i);
      flags_we_i <= 1'b0;
      sat_set_i <= 1'b0;
      cond_i <= i[3:0];
      @(posedge clk_i);
      #1;
      cmp({31'h0, cond_pass_o}, {31'h0, ceval(i[3:0], rnd[3:0])});
    end
    cmp(status_o, {rnd[3:0], 1'b1, 27'h0d3});
    wr_st(1'b0, 32'h13);
    #1;
    cmp(status_o, 32'h13);
    run(32'h13, 0, VEC_UND, 32'h9b, 32'h4, 32'h0);
    run(32'h33, 0, VEC_UND, 32'h9b, 32'h2, 32'h0);
    run(32'h0100_0013, 0, VEC_UND, 32'h9b, 32'h4, 32'h0);
    run(32'h0100_0033, 0, VEC_UND, 32'h9b, 32'h4, 32'h0);
    run(32'h13, 1, VEC_SWINT, 32'h93, 32'h4, 32'h0);
    run(32'h33, 1, VEC_SWINT, 32'h93, 32'h2, 32'h0);
    run(32'h13, 2, VEC_PABT, 32'h97, 32'h4, 32'h4);
    run(32'h13, 3, VEC_PABT, 32'h97, 32'h4, 32'h4);
    run(32'h13, 4, VEC_IRQ, 32'h92, 32'h4, 32'h4);
    fetch(1'b1, 1'b0, 1'b1);
    fetch(1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge clk_i);
    pc_i <= 32'h0000_0200;
    exp_q.push_back(VEC_DABT);
    exp_q.push_back(VEC_FIQ);
    src(4'h6, 4'h0, 4'h3);
    wait_load();
    wait_load();
    cmp(status_o, 32'hd1);
    cmp(saved_status_o, 32'h97);
    rd(LINK_IDX, 32'h204);
    src(4'h0, 4'h4, 4'h0);
    ret(32'h200);
    cmp(status_o, 32'h97);
    rd(LINK_IDX, 32'h208);
    ret(32'h200);
    cmp(status_o, 32'h13);
    wreg(SP_IDX, 32'ha5a5_0001);
    wr_st(1'b0, 32'h12);
    rd(SP_IDX, 32'h0);
    wreg(HI_FIRST, 32'h0000_0b0b);
    wr_st(1'b0, 32'h11);
    rd(HI_FIRST, 32'h0);
    wreg(HI_FIRST, 32'h0000_0c0c);
    wr_st(1'b1, 32'h1234_5617);
    #1;
    cmp(saved_status_o, 32'h1234_5617);
    wr_st(1'b0, 32'h13);
    rd(SP_IDX, 32'ha5a5_0001);
    rd(HI_FIRST, 32'h0000_0b0b);
    exp_q.push_back(VEC_RESET);
    src(4'hf, 4'h0, 4'h0);
    wait_load();
    cmp(status_o, 32'hd3);
    src(4'h0, 4'hc, 4'h0);
    repeat (4) @(posedge clk_i);
    cmp(32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
